// ==== hdl/lewf_consts.svh ====
// Offsets, field codes, reset values and timing counts of the list word formatter
`ifndef LEWF_CONSTS_SVH
`define LEWF_CONSTS_SVH
`define LEWF_ADDR_CTRL 8'h00
`define LEWF_ADDR_STAMP 8'h04
`define LEWF_ADDR_STATUS 8'h08
`define LEWF_ADDR_TIMERS 8'h0c
`define LEWF_CTRL_RESET 32'h0000_0003
`define LEWF_STAMP_RESET 7'h00
`define LEWF_FMT_2B 8'h00
`define LEWF_FMT_4S 8'h05
`define LEWF_FMT_4B 8'h01
`define LEWF_FMT_6S 8'h1a
`define LEWF_FMT_6TS 8'h2a
`define LEWF_FMT_6T 8'h22
`define LEWF_FMT_6LS 8'h32
`define LEWF_FMT_6B 8'h02
`define LEWF_FMT_8LTS 8'h5b
`define LEWF_FMT_8TS 8'hdb
`define LEWF_FMT_8TLS 8'hf3
`define LEWF_FMT_8LT 8'h43
`define LEWF_FMT_8T 8'hc3
`define LEWF_FMT_8L 8'h03
`define LEWF_CLK_HZ 25000000
`define LEWF_TIMER_MS 1
`define LEWF_TIMER_CYCLES (`LEWF_CLK_HZ / 1000 * `LEWF_TIMER_MS)
`define LEWF_BUF_BITS 384
`endif

// ==== hdl/lewf_pkg.sv ====
// Types shared by the list word formatter and its bench
package lewf_pkg;
	typedef struct packed {
		logic [2:0] channel;
		logic falling;
		logic [53:0] time_val;
		logic [15:0] tag;
	} lewf_stop_type;
	typedef struct packed {
		logic [2:0] index;
		logic [15:0] data;
		logic [31:0] time_val;
	} lewf_single_type;
	typedef struct packed {
		logic auxiliary_input_a;
		logic auxiliary_input_b;
		logic [7:0] mask;
		logic [127:0] data;
		logic [47:0] time_val;
		logic [95:0] scaler;
	} lewf_coinc_type;
	typedef struct packed {
		logic count_preset;
		logic armed;
		logic sweep_active_flag;
		logic rt_preset;
		logic [7:0] conv_busy;
		logic [47:0] sweep_count;
		logic [31:0] counter_one;
	} lewf_acq_type;
	typedef enum logic {LEWF_IDLE, LEWF_SEND} lewf_state_type;
endpackage

// ==== hdl/lewf_formatter.sv ====
// List-mode event word formatter with AHB-Lite control registers
`timescale 1ns/10ps
`default_nettype none
`include "lewf_consts.svh"

// Contract
// [R1] Channel number 1..6 sits in the low bits of every stop word; 6 is start.
// [R2] Bit three of a stop word is 1 for falling edge, 0 for rising.
// [R3] Formats with a lost flag set their top bit after the fast FIFO was full; 8TLS sets bit 47 instead.
// [R4] The format selector fixes length, time width, tag, sweep and lost fields.
// [R5] Each stop event goes out as exactly 2, 4, 6 or 8 bytes.
// [R6] Multi-byte words go out least significant byte first.
// [R7] With any converter enabled, only 8-byte words and 8-byte multiples.
// [R8] In 8-byte words bits 0..2 give type: 1..6 stop, 0 timer, 7 converter.
// [R9] With converters enabled a timer word with low nibble 1000 comes every ms.
// [R10] Timer bits 4..7: count preset, armed, sweep active, real-time preset.
// [R11] Timer bits 8..15 show converters one..eight, 0 meaning busy.
// [R12] Timer bits 16..31 low sweep count, bits 32..63 counter one.
// [R13] Single converter word: 111 in bits 0..2, index in 3..5, 0 in bit 6.
// [R14] Single converter word carries low nine sweep bits in bits 7..15.
// [R15] Single converter word: result in 16..31, time in 6.4 ns units in 32..63.
// [R16] Coincidence header: 111, aux flags in 3 and 4, then 0, 1, 0.
// [R17] Coincidence header bits 8..15 flag converters with valid data.
// [R18] Header is followed by converter data, time stamp, sweep count, scalers.
// [R19] Records are padded with up to three dummy halfwords to 8-byte multiples.
// [R20] Longest-range format: 54-bit time, tag in 58..62, lost flag in 63.
// [R21] The two 6-byte tagged formats hold eight tag bits in 40..47.
// [R22] 16-bit sweep count with 28-bit time sits in bits 32..47.
// [R23] Millisecond tick from a free divider; timer word waits for word in progress.
module lewf_formatter
	import lewf_pkg::*;
#(
	parameter int TIMER_CYCLES = `LEWF_TIMER_CYCLES
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic stop_valid,
	input wire lewf_stop_type stop_event,
	output logic stop_ready,
	input wire logic single_valid,
	input wire lewf_single_type single_event,
	output logic single_ready,
	input wire logic coinc_valid,
	input wire lewf_coinc_type coinc_event,
	output logic coinc_ready,
	input wire lewf_acq_type acq,
	input wire logic fifo_full,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	input wire logic out_ready
);
	logic [31:0] ctrl_r;
	logic [6:0] stamp_r;
	logic [31:0] timers_r;
	logic wr_pend_r;
	logic [7:0] waddr_r;
	logic [7:0] raddr;
	logic [7:0] fmt;
	logic [7:0] conv_en;
	logic [7:0] eff_fmt;
	lewf_state_type state_r;
	logic [`LEWF_BUF_BITS-1:0] shift_r;
	logic [`LEWF_BUF_BITS-1:0] load_vec;
	logic [5:0] left_r;
	logic [5:0] load_len;
	logic lost_r;
	logic timer_pend_r;
	logic [31:0] div_r;
	logic tick;
	logic idle;
	logic grant_timer;
	logic grant_coinc;
	logic grant_single;
	logic grant_stop;
	logic take_byte;
	logic [63:0] stop_word;
	logic [63:0] timer_word;
	logic [63:0] single_word;

	// Byte length of a stop word for one format code
	function automatic logic [5:0] fmt_bytes(input logic [7:0] f);
		case (f)
			`LEWF_FMT_2B: fmt_bytes = 6'd2;
			`LEWF_FMT_4S, `LEWF_FMT_4B: fmt_bytes = 6'd4;
			`LEWF_FMT_6S, `LEWF_FMT_6TS, `LEWF_FMT_6T, `LEWF_FMT_6LS, `LEWF_FMT_6B:
				fmt_bytes = 6'd6;
			default: fmt_bytes = 6'd8;
		endcase
	endfunction

	// Format carries the data lost flag
	function automatic logic fmt_has_lost(input logic [7:0] f);
		case (f)
			`LEWF_FMT_6LS, `LEWF_FMT_8LTS, `LEWF_FMT_8TLS, `LEWF_FMT_8LT: fmt_has_lost = 1'b1;
			`LEWF_FMT_2B, `LEWF_FMT_4S, `LEWF_FMT_4B, `LEWF_FMT_6S, `LEWF_FMT_6TS,
			`LEWF_FMT_6T, `LEWF_FMT_6B, `LEWF_FMT_8TS, `LEWF_FMT_8T: fmt_has_lost = 1'b0;
			default: fmt_has_lost = 1'b1;
		endcase
	endfunction

	// Stop word layout per format, channel and edge in the low nibble
	function automatic logic [63:0] tdc_word(input logic [7:0] f, input lewf_stop_type s,
		input logic [15:0] sw, input logic lost);
		logic [3:0] ch;
		ch = {s.falling, s.channel}; // R1 R2
		case (f) // R4
			`LEWF_FMT_2B: tdc_word = {48'h0, s.time_val[11:0], ch};
			`LEWF_FMT_4S: tdc_word = {32'h0, sw[7:0], s.time_val[19:0], ch};
			`LEWF_FMT_4B: tdc_word = {32'h0, s.time_val[27:0], ch};
			`LEWF_FMT_6S: tdc_word = {16'h0, sw, s.time_val[27:0], ch}; // R22
			`LEWF_FMT_6TS: tdc_word = {16'h0, s.tag[7:0], sw[7:0], s.time_val[27:0], ch}; // R21
			`LEWF_FMT_6T: tdc_word = {16'h0, s.tag[7:0], s.time_val[35:0], ch}; // R21
			`LEWF_FMT_6LS: tdc_word = {16'h0, lost, sw[6:0], s.time_val[35:0], ch}; // R3
			`LEWF_FMT_6B: tdc_word = {16'h0, s.time_val[43:0], ch};
			`LEWF_FMT_8LTS: tdc_word = {lost, s.tag[14:0], sw, s.time_val[27:0], ch}; // R22
			`LEWF_FMT_8TS: tdc_word = {s.tag, sw, s.time_val[27:0], ch}; // R22
			`LEWF_FMT_8TLS: tdc_word = {s.tag, lost, sw[6:0], s.time_val[35:0], ch};
			`LEWF_FMT_8LT: tdc_word = {lost, s.tag[14:0], s.time_val[43:0], ch};
			`LEWF_FMT_8T: tdc_word = {s.tag, s.time_val[43:0], ch};
			default: tdc_word = {lost, s.tag[4:0], s.time_val, ch}; // R20
		endcase
	endfunction

	assign fmt = ctrl_r[7:0];
	assign conv_en = ctrl_r[15:8];
	// Converters enabled force an 8-byte layout
	assign eff_fmt = (conv_en != 8'h00 && fmt_bytes(fmt) != 6'd8) ? `LEWF_FMT_8L : fmt; // R7

	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign raddr = {haddr[7:2], 2'b00};

	// Write address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			waddr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			waddr_r <= raddr;
		end
	end

	// Control registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= `LEWF_CTRL_RESET;
			stamp_r <= `LEWF_STAMP_RESET;
		end
		else if (wr_pend_r)
		begin
			if (waddr_r == `LEWF_ADDR_CTRL)
				ctrl_r <= {16'h0000, hwdata[15:0]};
			if (waddr_r == `LEWF_ADDR_STAMP)
				stamp_r <= hwdata[6:0];
		end
	end

	// Read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			case (raddr)
				`LEWF_ADDR_CTRL: hrdata <= ctrl_r;
				`LEWF_ADDR_STAMP: hrdata <= {25'h0, stamp_r};
				`LEWF_ADDR_STATUS: hrdata <= {29'h0, timer_pend_r, lost_r, (state_r == LEWF_SEND)};
				`LEWF_ADDR_TIMERS: hrdata <= timers_r;
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Free-running millisecond divider
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_r <= 32'h0;
		else if (tick)
			div_r <= 32'h0;
		else
			div_r <= div_r + 32'h1;
	end
	assign tick = (div_r == 32'(TIMER_CYCLES - 1)); // R23

	// Arbitration: timer first, only between words
	assign idle = (state_r == LEWF_IDLE);
	assign grant_timer = idle && timer_pend_r; // R23
	assign grant_coinc = idle && !timer_pend_r && coinc_valid;
	assign grant_single = idle && !timer_pend_r && !coinc_valid && single_valid;
	assign grant_stop = idle && !timer_pend_r && !coinc_valid && !single_valid && stop_valid;
	assign coinc_ready = grant_coinc;
	assign single_ready = grant_single;
	assign stop_ready = grant_stop;

	// Timer pending; a new tick wins over the clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_pend_r <= 1'b0;
		else if (tick && conv_en != 8'h00)
			timer_pend_r <= 1'b1; // R9
		else if (grant_timer)
			timer_pend_r <= 1'b0;
	end

	// Count of timer words emitted
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timers_r <= 32'h0;
		else if (grant_timer)
			timers_r <= timers_r + 32'h1;
	end

	// Sticky data lost; a full FIFO wins over the report
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lost_r <= 1'b0;
		else if (fifo_full)
			lost_r <= 1'b1; // R3
		else if (grant_stop && fmt_has_lost(eff_fmt))
			lost_r <= 1'b0;
	end

	// Word images
	assign stop_word = tdc_word(eff_fmt, stop_event, acq.sweep_count[15:0], lost_r);
	assign timer_word = {acq.counter_one, acq.sweep_count[15:0], ~acq.conv_busy, // R11 R12
		acq.rt_preset, acq.sweep_active_flag, acq.armed, acq.count_preset, 4'b1000}; // R9 R10
	assign single_word = {single_event.time_val, single_event.data, // R15
		acq.sweep_count[8:0], 1'b0, single_event.index, 3'b111}; // R13 R14 R8

	// Load image and length for the granted source
	always_comb
	begin
		int n;
		n = 0;
		load_vec = '0;
		load_len = 6'd0;
		if (grant_timer)
		begin
			load_vec[63:0] = timer_word;
			load_len = 6'd8;
		end
		else if (grant_coinc)
		begin
			load_vec[15:0] = {coinc_event.mask, 1'b0, 1'b1, 1'b0, // R16 R17
				coinc_event.auxiliary_input_b, coinc_event.auxiliary_input_a, 3'b111};
			n = 1;
			for (int i = 0; i < 8; i++)
			begin
				if (coinc_event.mask[i])
				begin
					load_vec[n*16 +: 16] = coinc_event.data[i*16 +: 16]; // R18
					n = n + 1;
				end
			end
			for (int i = 0; i < 3; i++)
			begin
				if ((i < 2 && (stamp_r[0] || stamp_r[1])) || (i == 2 && stamp_r[1]))
				begin
					load_vec[n*16 +: 16] = coinc_event.time_val[i*16 +: 16]; // R18
					n = n + 1;
				end
			end
			for (int i = 0; i < 3; i++)
			begin
				if ((i == 0 && (stamp_r[2] || stamp_r[3])) || (i > 0 && stamp_r[3]))
				begin
					load_vec[n*16 +: 16] = acq.sweep_count[i*16 +: 16]; // R18
					n = n + 1;
				end
			end
			for (int i = 0; i < 6; i++)
			begin
				if (stamp_r[4 + i/2])
				begin
					load_vec[n*16 +: 16] = coinc_event.scaler[i*16 +: 16]; // R18
					n = n + 1;
				end
			end
			n = (n + 3) / 4 * 4; // R19 R7
			load_len = 6'(n * 2);
		end
		else if (grant_single)
		begin
			load_vec[63:0] = single_word;
			load_len = 6'd8;
		end
		else if (grant_stop)
		begin
			load_vec[63:0] = stop_word;
			load_len = fmt_bytes(eff_fmt); // R5 R4
		end
	end

	// Byte serialiser, least significant byte first
	assign take_byte = out_valid && out_ready;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= LEWF_IDLE;
			shift_r <= '0;
			left_r <= 6'd0;
		end
		else
		begin
			case (state_r)
				LEWF_IDLE:
				begin
					if (load_len != 6'd0)
					begin
						shift_r <= load_vec;
						left_r <= load_len;
						state_r <= LEWF_SEND;
					end
				end
				LEWF_SEND:
				begin
					if (take_byte)
					begin
						shift_r <= shift_r >> 8; // R6
						left_r <= left_r - 6'd1;
						if (left_r == 6'd1)
							state_r <= LEWF_IDLE;
					end
				end
				default: state_r <= LEWF_IDLE;
			endcase
		end
	end
	assign out_valid = (state_r == LEWF_SEND);
	assign out_data = shift_r[7:0];
	assign out_last = out_valid && (left_r == 6'd1);

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_stop_load;
		grant_stop && conv_en != 8'h00;
	endsequence
	sequence s_eight_out;
		out_valid && left_r == 6'd8;
	endsequence

	a_lsb_first: assert property (grant_stop |=> out_data == $past(stop_word[7:0])) // R6
		else $error("stop word not sent low byte first");
	a_stop_len: assert property (grant_stop |=> left_r == $past(fmt_bytes(eff_fmt))) // R5
		else $error("stop word length wrong");
	a_conv_eight: assert property (s_stop_load |=> s_eight_out) // R7
		else $error("stop word not 8 bytes with converters on");
	a_timer_nibble: assert property (grant_timer |=> out_data[3:0] == 4'b1000) // R9
		else $error("timer word pattern wrong");
	a_single_type: assert property (grant_single |=> out_data[2:0] == 3'b111 && !out_data[6]) // R13
		else $error("single word type bits wrong");
	a_coinc_pad: assert property (grant_coinc |=> left_r[2:0] == 3'd0 && left_r != 6'd0) // R19
		else $error("coincidence record not 8-byte aligned");
	a_coinc_head: assert property (grant_coinc |=> out_data[7:5] == 3'b010) // R16
		else $error("coincidence header bits wrong");
	a_no_interleave: assert property (out_valid && !out_last |=> !stop_ready && !coinc_ready) // R23
		else $error("new word granted mid word");
	a_tick_pend: assert property ( // R23
		tick && conv_en != 8'h00 |=> timer_pend_r ##[0:64] grant_timer)
		else $error("timer word not queued");
	a_lost_top: assert property ( // R3
		grant_stop && lost_r && eff_fmt == `LEWF_FMT_8L |-> stop_word[63])
		else $error("lost flag missing");
endmodule
`default_nettype wire

// ==== tb/lewf_host_model.sv ====
// Host-side reader that drains the formatted byte stream
`timescale 1ns/10ps
`default_nettype none
module lewf_host_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic slow,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	output logic out_ready
);
	logic [8:0] q[$];
	// Ready paced by the slow switch, stalling every other cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_ready <= 1'b0;
		else
			out_ready <= slow ? ~out_ready : 1'b1;
	end
	// Capture each accepted byte with its end flag
	always @(posedge hclk)
	begin
		if (hresetn && out_valid && out_ready)
			q.push_back({out_last, out_data});
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the list word formatter
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lewf_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, fifo_full;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic stop_valid, stop_ready, single_valid, single_ready, coinc_valid, coinc_ready;
	lewf_stop_type stop_event;
	lewf_single_type single_event;
	lewf_coinc_type coinc_event;
	lewf_acq_type acq;
	logic out_valid, out_last, out_ready;
	logic [7:0] out_data;
	logic [31:0] rd;
	logic [63:0] w;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	// Remaining stop layouts: format code, byte count and expected word
	logic [7:0] fmts [10] = '{8'h05, 8'h01, 8'h2a, 8'h32, 8'h02, 8'h5b, 8'hdb, 8'hf3, 8'h43,
		8'hc3};
	int lens [10] = '{4, 4, 6, 6, 6, 8, 8, 8, 8, 8};
	logic [63:0] exps [10] = '{64'hef78_9ab4, 64'h5678_9ab4, 64'h3eef_5678_9ab4,
		64'h6f34_5678_9ab4, 64'h1234_5678_9ab4, 64'h1c3e_beef_5678_9ab4,
		64'h9c3e_beef_5678_9ab4, 64'h9c3e_6f34_5678_9ab4, 64'h1c3e_1234_5678_9ab4,
		64'h9c3e_1234_5678_9ab4};
	lewf_formatter #(.TIMER_CYCLES(50)) lewf_formatter_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .stop_valid(stop_valid), .stop_event(stop_event),
		.stop_ready(stop_ready), .single_valid(single_valid), .single_event(single_event),
		.single_ready(single_ready), .coinc_valid(coinc_valid), .coinc_event(coinc_event),
		.coinc_ready(coinc_ready), .acq(acq), .fifo_full(fifo_full), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready));
	lewf_host_model host_inst (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last),
		.out_ready(out_ready));
	// Clock and watchdog
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			wrap_up;
		end
	end
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One single AHB-Lite word transfer
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Offer one event of kind k and hold it until taken
	task fire(input int k);
		@(posedge hclk);
		stop_valid <= (k == 0);
		single_valid <= (k == 1);
		coinc_valid <= (k == 2);
		do @(posedge hclk);
		while ((k == 0 ? stop_ready : k == 1 ? single_ready : coinc_ready) !== 1'b1);
		stop_valid <= 1'b0;
		single_valid <= 1'b0;
		coinc_valid <= 1'b0;
	endtask
	// Gather n bytes, low byte first, and check the end marker
	task take(input int n);
		logic [8:0] b;
		logic [7:0] lasts;
		w = '0;
		lasts = '0;
		for (int i = 0; i < 4000 && host_inst.q.size() < n; i++)
			@(posedge hclk);
		for (int i = 0; i < n; i++)
		begin
			b = host_inst.q.pop_front();
			w[8*i+:8] = b[7:0];
			lasts[i] = b[8];
		end
		chk(lasts, 64'h1 << (n - 1));
	endtask
	// Next 8-byte word that is not a timer word
	task take8;
		take(8);
		for (int i = 0; i < 8 && w[2:0] == 3'h0; i++)
			take(8);
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		slow = 1'b1;
		fifo_full = 1'b0;
		stop_valid = 1'b0;
		single_valid = 1'b0;
		coinc_valid = 1'b0;
		stop_event = '{3'h3, 1'b1, 54'habc, 16'h0};
		single_event = '{3'h5, 16'h1234, 32'hdeadbeef};
		coinc_event = '{1'b1, 1'b0, 8'h05, 128'h3333_0000_1111, 48'h0, 96'h0};
		acq = '{1'b1, 1'b0, 1'b1, 1'b0, 8'h0f, 48'h0000_0000_beef, 32'h0123_4567};
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Register reset values and an unmapped place
		ahb(1'b0, 32'h00, 32'h0);
		chk(rd, 64'h3);
		ahb(1'b0, 32'h04, 32'h0);
		chk(rd, 64'h0);
		ahb(1'b0, 32'h40, 32'h0);
		chk(rd, 64'h0);
		// Short format with a falling edge, host stalling
		ahb(1'b1, 32'h00, 32'h00);
		fire(0);
		take(2);
		chk(w, 64'habcb);
		// Tagged 6-byte format on the start channel
		ahb(1'b1, 32'h00, 32'h22);
		stop_event <= '{3'h6, 1'b0, 54'h1_2345_6789, 16'h00a5};
		fire(0);
		take(6);
		chk(w, 64'ha5_1234_5678_96);
		// Sweep count beside a 28-bit time
		slow <= 1'b0;
		ahb(1'b1, 32'h00, 32'h1a);
		stop_event <= '{3'h1, 1'b0, 54'h123_4567, 16'h0};
		fire(0);
		take(6);
		chk(w, 64'hbeef_1234_5671);
		// Longest range with lost flag set then cleared, back to back
		ahb(1'b1, 32'h00, 32'h03);
		@(posedge hclk);
		fifo_full <= 1'b1;
		@(posedge hclk);
		fifo_full <= 1'b0;
		stop_event <= '{3'h2, 1'b1, 54'h3_0000_0000_0001, 16'h0015};
		fire(0);
		fire(0);
		take(8);
		chk(w, 64'hd430_0000_0000_001a);
		take(8);
		chk(w, 64'h5430_0000_0000_001a);
		// Every other stop layout once, sweep 0xbeef beside the time
		stop_event <= '{3'h4, 1'b0, 54'h0123_4567_89ab, 16'h9c3e};
		foreach (fmts[i])
		begin
			ahb(1'b1, 32'h00, {24'h0, fmts[i]});
			fire(0);
			take(lens[i]);
			chk(w, exps[i]);
		end
		// Converters on force 8-byte words even for the short format
		ahb(1'b1, 32'h00, 32'h0100);
		stop_event <= '{3'h3, 1'b1, 54'habc, 16'h0};
		fire(0);
		take8;
		chk(w, 64'h0000_0000_0000_abcb);
		fire(1);
		take8;
		chk(w, 64'hdead_beef_1234_77af);
		slow <= 1'b1;
		fire(2);
		take8;
		chk(w, 64'h0000_3333_1111_054f);
		// Periodic timer word carrying status and counters
		take(8);
		for (int i = 0; i < 8 && w[2:0] != 3'h0; i++)
			take(8);
		chk(w, 64'h0123_4567_beef_f058);
		wrap_up;
	end
endmodule
`default_nettype wire
